// >>> rtl/pesd_pkg.sv
// constants, carriers and enumerations for the performance event selection decoder
`default_nettype none

package pesd_pkg;

   // widths of the selection fields and of the per-cycle occurrence counts
   localparam int EVT_W = 8;                       // event number width
   localparam int MASK_W = 8;                      // qualifier mask width
   localparam int SRC_W = 3;                       // width of a per-cycle occurrence count
   localparam int NUM_PORTS = 6;                   // issue ports that dispatch micro-ops
   localparam int PORT_IDX_W = 3;                  // width of an issue port index

   // event numbers understood by the decoder
   localparam logic [EVT_W-1:0] EVT_IDLE = 8'h00;        // no event selected
   localparam logic [EVT_W-1:0] EVT_PORT_DISP = 8'hA1;   // port dispatch cycles
   localparam logic [EVT_W-1:0] EVT_MACRO_DEC = 8'hAA;   // instruction decode group
   localparam logic [EVT_W-1:0] EVT_STACK = 8'hAB;       // stack pointer group
   localparam logic [EVT_W-1:0] EVT_VEC_ALL = 8'hB0;     // vector micro-ops, stores excluded
   localparam logic [EVT_W-1:0] EVT_VEC_SAT = 8'hB1;     // saturating vector micro-ops
   localparam logic [EVT_W-1:0] EVT_VEC_TYPE = 8'hB3;    // vector micro-op type group

   // qualifier masks
   localparam logic [MASK_W-1:0] MASK_NONE = 8'h00;      // event takes no qualifier
   localparam logic [MASK_W-1:0] MASK_PORT0 = 8'h01;     // port 0, shifted left per port
   localparam logic [MASK_W-1:0] MASK_DEC_ALL = 8'h01;   // every instruction decoded
   localparam logic [MASK_W-1:0] MASK_DEC_CISC = 8'h08;  // complex instructions decoded
   localparam logic [MASK_W-1:0] MASK_SP_SYNC = 8'h01;   // stack pointer synchronisation
   localparam logic [MASK_W-1:0] MASK_SP_ADD = 8'h02;    // decoder stack pointer additions
   localparam logic [MASK_W-1:0] MASK_VEC_MUL = 8'h01;   // packed multiply
   localparam logic [MASK_W-1:0] MASK_VEC_SHIFT = 8'h02; // packed shift
   localparam logic [MASK_W-1:0] MASK_VEC_PACK = 8'h04;  // pack

   // class of occurrence that a selection counts
   typedef enum logic [3:0] {
      CLS_IDLE,
      CLS_NONE,
      CLS_PORT,
      CLS_DEC,
      CLS_CISC,
      CLS_SP_SYNC,
      CLS_SP_ADD,
      CLS_VEC_ALL,
      CLS_VEC_SAT,
      CLS_VEC_MUL,
      CLS_VEC_SHIFT,
      CLS_VEC_PACK
   } pesd_class_e;

   // one counter's programmed selection
   typedef struct packed {
      logic [EVT_W-1:0] evt;                       // event number
      logic [MASK_W-1:0] mask;                     // qualifier mask
   } pesd_sel_s;

   // occurrences reported by the pipeline in the current cycle
   typedef struct packed {
      logic [NUM_PORTS-1:0] port_dispatch_cycles;  // one bit per issue port
      logic [SRC_W-1:0] insts_decoded;             // instructions decoded
      logic complex_insts_decoded_count;           // a complex instruction decoded
      logic [SRC_W-1:0] stack_ptr_sync_count;      // stack pointer synchronisations
      logic [SRC_W-1:0] stack_ptr_auto_add_count;  // decoder stack pointer additions
      logic [SRC_W-1:0] vector_uops_executed;      // vector micro-ops, stores excluded
      logic [SRC_W-1:0] vector_saturating_uops;    // saturating vector micro-ops
      logic [SRC_W-1:0] vector_multiply_uops;      // packed multiply micro-ops
      logic [SRC_W-1:0] vector_shift_uops;         // packed shift micro-ops
      logic [SRC_W-1:0] vector_pack_uops;          // pack micro-ops
   } pesd_src_s;

   // result of matching one selection against the table
   typedef struct packed {
      pesd_class_e cls;                            // occurrence class to count
      logic [PORT_IDX_W-1:0] port;                 // issue port for port dispatch
      logic bad;                                   // selection unlisted or not allowed
   } pesd_match_s;

endpackage

`default_nettype wire

// >>> rtl/pesd_selmatch.sv
// table match of one counter's event selection
`timescale 1ns/100ps
`default_nettype none

module pesd_selmatch (
   input wire pesd_pkg::pesd_sel_s sel,            // programmed selection
   input wire logic on_cnt_zero,                   // this is programmable counter zero
   output var pesd_pkg::pesd_match_s match         // class, port and legality
);

   // walk the event table; anything not listed counts nothing
   always_comb begin
      match = '{cls: pesd_pkg::CLS_NONE, port: '0, bad: 1'b1};
      unique case (sel.evt)
         pesd_pkg::EVT_IDLE: begin
            // counter parked, not an error
            match.cls = pesd_pkg::CLS_IDLE;
            match.bad = 1'b0;
         end
         pesd_pkg::EVT_PORT_DISP: begin
            // one mask bit names one port
            for (int p = 0; p < pesd_pkg::NUM_PORTS; p++) begin
               if (sel.mask == (pesd_pkg::MASK_PORT0 << p)) begin
                  match.cls = pesd_pkg::CLS_PORT;
                  match.port = p[pesd_pkg::PORT_IDX_W-1:0];
                  match.bad = 1'b0;
               end
            end
            // port dispatch refused off counter zero
            if (!on_cnt_zero) begin
               match.cls = pesd_pkg::CLS_NONE;
               match.bad = 1'b1;
            end
         end
         pesd_pkg::EVT_MACRO_DEC: begin
            if (sel.mask == pesd_pkg::MASK_DEC_ALL) begin
               match.cls = pesd_pkg::CLS_DEC;
               match.bad = 1'b0;
            end else if (sel.mask == pesd_pkg::MASK_DEC_CISC) begin
               match.cls = pesd_pkg::CLS_CISC;
               match.bad = 1'b0;
            end
         end
         pesd_pkg::EVT_STACK: begin
            if (sel.mask == pesd_pkg::MASK_SP_SYNC) begin
               match.cls = pesd_pkg::CLS_SP_SYNC;
               match.bad = 1'b0;
            end else if (sel.mask == pesd_pkg::MASK_SP_ADD) begin
               match.cls = pesd_pkg::CLS_SP_ADD;
               match.bad = 1'b0;
            end
         end
         pesd_pkg::EVT_VEC_ALL: begin
            if (sel.mask == pesd_pkg::MASK_NONE) begin
               match.cls = pesd_pkg::CLS_VEC_ALL;
               match.bad = 1'b0;
            end
         end
         pesd_pkg::EVT_VEC_SAT: begin
            if (sel.mask == pesd_pkg::MASK_NONE) begin
               match.cls = pesd_pkg::CLS_VEC_SAT;
               match.bad = 1'b0;
            end
         end
         pesd_pkg::EVT_VEC_TYPE: begin
            if (sel.mask == pesd_pkg::MASK_VEC_MUL) begin
               match.cls = pesd_pkg::CLS_VEC_MUL;
               match.bad = 1'b0;
            end else if (sel.mask == pesd_pkg::MASK_VEC_SHIFT) begin
               match.cls = pesd_pkg::CLS_VEC_SHIFT;
               match.bad = 1'b0;
            end else if (sel.mask == pesd_pkg::MASK_VEC_PACK) begin
               match.cls = pesd_pkg::CLS_VEC_PACK;
               match.bad = 1'b0;
            end
         end
         default: begin
            // unlisted event keeps the default no-count answer
            match.bad = 1'b1;
         end
      endcase
   end

endmodule

`default_nettype wire

// >>> rtl/pesd_decode.sv
// performance event selection decoder: selection to per-cycle counter increment
//
// Behaviour
// - event A1H masks 01H-20H pick ports 0-5
// - port dispatch adds one per dispatching cycle
// - port dispatch selections valid on counter zero
// - AAH/01H counts every instruction decoded
// - AAH/08H counts complex instructions decoded
// - ABH/01H counts stack pointer synchronisations
// - ABH/02H counts decoder stack pointer additions
// - B0H/00H counts vector micro-ops, stores excluded
// - B1H/00H counts saturating vector micro-ops
// - B3H masks 01H/02H/04H: multiply, shift, pack
`timescale 1ns/100ps
`default_nettype none

module pesd_decode #(
   parameter int NUM_CNT = 2                       // programmable counters served
) (
   input wire logic ref_clk,                       // core clock, 200 MHz
   input wire logic rst,                           // asynchronous reset, active high
   input wire pesd_pkg::pesd_sel_s [NUM_CNT-1:0] sel_in, // new selection per counter
   input wire logic [NUM_CNT-1:0] sel_load,        // take sel_in for that counter
   input wire logic [NUM_CNT-1:0] cnt_enable,      // counter is counting
   input wire pesd_pkg::pesd_src_s src,            // pipeline occurrences this cycle
   output logic [NUM_CNT-1:0][pesd_pkg::SRC_W-1:0] cnt_inc_q, // amount to add
   output logic [NUM_CNT-1:0] cnt_hit_q,           // amount to add is non-zero
   output logic [NUM_CNT-1:0] sel_bad_q,           // selection unlisted or refused
   output var pesd_pkg::pesd_sel_s [NUM_CNT-1:0] sel_q // selection now in force
);

   // complete state of the decoder
   typedef struct packed {
      pesd_pkg::pesd_sel_s [NUM_CNT-1:0] sel;      // selection in force per counter
      logic [NUM_CNT-1:0][pesd_pkg::SRC_W-1:0] inc; // registered increment
      logic [NUM_CNT-1:0] hit;                     // registered non-zero flag
      logic [NUM_CNT-1:0] bad;                     // registered refusal flag
   } pesd_state_s;

   pesd_state_s st_q;                              // registered state
   pesd_state_s st_d;                              // next state
   pesd_pkg::pesd_match_s [NUM_CNT-1:0] match;     // table match per counter

   // pick the occurrence count for one match
   function automatic logic [pesd_pkg::SRC_W-1:0] pick(
      input pesd_pkg::pesd_match_s m,
      input pesd_pkg::pesd_src_s s
   );
      logic [pesd_pkg::SRC_W-1:0] v;
      v = '0;
      unique case (m.cls)
         pesd_pkg::CLS_IDLE: begin
            // parked counter adds nothing
            v = '0;
         end
         pesd_pkg::CLS_NONE: begin
            v = '0;
         end
         pesd_pkg::CLS_PORT: begin
            // one per cycle, at most one micro-op per port
            v = {{(pesd_pkg::SRC_W-1){1'b0}}, s.port_dispatch_cycles[m.port]};
         end
         pesd_pkg::CLS_DEC: begin
            v = s.insts_decoded;
         end
         pesd_pkg::CLS_CISC: begin
            // only one complex decode per cycle
            v = {{(pesd_pkg::SRC_W-1){1'b0}}, s.complex_insts_decoded_count};
         end
         pesd_pkg::CLS_SP_SYNC: begin
            v = s.stack_ptr_sync_count;
         end
         pesd_pkg::CLS_SP_ADD: begin
            v = s.stack_ptr_auto_add_count;
         end
         pesd_pkg::CLS_VEC_ALL: begin
            // source already leaves out register-to-memory moves
            v = s.vector_uops_executed;
         end
         pesd_pkg::CLS_VEC_SAT: begin
            v = s.vector_saturating_uops;
         end
         pesd_pkg::CLS_VEC_MUL: begin
            v = s.vector_multiply_uops;
         end
         pesd_pkg::CLS_VEC_SHIFT: begin
            v = s.vector_shift_uops;
         end
         pesd_pkg::CLS_VEC_PACK: begin
            v = s.vector_pack_uops;
         end
      endcase
      return v;
   endfunction

   // one table match per counter, counter zero alone may count ports
   for (genvar g = 0; g < NUM_CNT; g++) begin : g_match
      pesd_selmatch u_match (
         .sel(st_q.sel[g]),
         .on_cnt_zero(g == 0),
         .match(match[g])
      );
   end

   // next state: load selections, compute increments
   always_comb begin
      st_d = st_q;
      for (int i = 0; i < NUM_CNT; i++) begin
         // a new selection takes effect from the next cycle
         if (sel_load[i]) begin
            st_d.sel[i] = sel_in[i];
         end
         // add this cycle's occurrences of the selected class
         if (cnt_enable[i]) begin
            st_d.inc[i] = pick(match[i], src);
         end else begin
            // stopped counter sees nothing
            st_d.inc[i] = '0;
         end
         st_d.hit[i] = (st_d.inc[i] != '0);
         // refusal shown whether or not counting
         st_d.bad[i] = match[i].bad;
      end
   end

   // state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs come straight from the state register
   assign cnt_inc_q = st_q.inc;
   assign cnt_hit_q = st_q.hit;
   assign sel_bad_q = st_q.bad;
   assign sel_q = st_q.sel;

endmodule

`default_nettype wire

// >>> tb/pesd_decode_props.sv
// assertion checker for the event selection decoder
`timescale 1ns/100ps
`default_nettype none
module pesd_decode_props #(
   parameter int NUM_CNT = 2 // counters served
) (
   input wire logic ref_clk, // core clock
   input wire logic rst, // async reset
   input wire pesd_pkg::pesd_sel_s [NUM_CNT-1:0] sel_in, // new selection
   input wire logic [NUM_CNT-1:0] sel_load, // load strobe
   input wire logic [NUM_CNT-1:0] cnt_enable, // counting enable
   input wire pesd_pkg::pesd_src_s src, // occurrences
   input wire logic [NUM_CNT-1:0][pesd_pkg::SRC_W-1:0] cnt_inc_q, // increment
   input wire logic [NUM_CNT-1:0] cnt_hit_q, // non-zero increment
   input wire logic [NUM_CNT-1:0] sel_bad_q, // refused selection
   input wire pesd_pkg::pesd_sel_s [NUM_CNT-1:0] sel_q // selection in force
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (rst);
   hit_match_a: assert property (cnt_hit_q[0] == (cnt_inc_q[0] != 3'h0))
      else $error("hit flag disagrees with increment");
   enable_off_a: assert property (!cnt_enable[0] |=> cnt_inc_q[0] == 3'h0)
      else $error("disabled counter got an increment");
   load_take_a: assert property (sel_load[0] |=> sel_q[0] == $past(sel_in[0]))
      else $error("selection not taken on load");
   port_cnt1_a: assert property (sel_q[1].evt == 8'hA1 |=> sel_bad_q[1])
      else $error("port event accepted off counter zero");
   port_count_a: assert property (sel_q[0] == 16'hA104 && cnt_enable[0]
      |=> cnt_inc_q[0] == {2'h0, $past(src.port_dispatch_cycles[2])})
      else $error("port dispatch count wrong");
   dec_count_a: assert property (sel_q[0] == 16'hAA01 && cnt_enable[0]
      |=> cnt_inc_q[0] == $past(src.insts_decoded)) else $error("decode count wrong");
   cisc_count_a: assert property (sel_q[0] == 16'hAA08 && cnt_enable[0]
      |=> cnt_inc_q[0] == {2'h0, $past(src.complex_insts_decoded_count)})
      else $error("complex count wrong");
   sat_count_a: assert property (sel_q[0] == 16'hB100 && cnt_enable[0]
      |=> cnt_inc_q[0] == $past(src.vector_saturating_uops)) else $error("sat count wrong");
   bad_zero_a: assert property (sel_bad_q[0] |-> cnt_inc_q[0] == 3'h0)
      else $error("refused selection counted");
   idle_ok_a: assert property (sel_q[0].evt == 8'h00 |=> !sel_bad_q[0])
      else $error("idle selection flagged");
endmodule
`default_nettype wire

// >>> tb/pesd_src_model.sv
// pipeline occurrence source: each multi-bit count field offset from one base value, complex count is its low bit
`timescale 1ns/100ps
`default_nettype none
module pesd_src_model (
   input wire logic [2:0] amt, // base count
   input wire logic [5:0] ports, // dispatching ports
   output var pesd_pkg::pesd_src_s src // occurrences this cycle
);
   // one bit per port, one complex at a time
   always_comb begin
      src.port_dispatch_cycles = ports;
      src.complex_insts_decoded_count = amt[0];
      src.insts_decoded = amt;
      src.stack_ptr_sync_count = amt + 3'h1;
      src.stack_ptr_auto_add_count = amt + 3'h2;
      src.vector_uops_executed = amt + 3'h3;
      src.vector_saturating_uops = amt + 3'h4;
      src.vector_multiply_uops = amt + 3'h5;
      src.vector_shift_uops = amt + 3'h6;
      src.vector_pack_uops = amt + 3'h7;
   end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the event selection decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
   typedef struct packed {
      pesd_pkg::pesd_sel_s sel; // selection
      logic cnt; // counter index
      logic [2:0] amt; // base count
      logic [5:0] ports; // ports
      logic [2:0] inc; // expected increment
      logic bad; // expected refusal
   } pesd_row_s;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   pesd_pkg::pesd_sel_s [1:0] sel_in = '0;
   logic [1:0] sel_load = 2'h0;
   logic [1:0] cnt_enable = 2'h3;
   logic [2:0] amt = 3'h0;
   logic [5:0] ports = 6'h00;
   pesd_pkg::pesd_src_s src;
   logic [1:0][2:0] cnt_inc_q;
   logic [1:0] cnt_hit_q;
   logic [1:0] sel_bad_q;
   pesd_pkg::pesd_sel_s [1:0] sel_q;
   int n_fail = 0;
   int cmp_count = 0;
   pesd_row_s rows [20] = '{
      '{16'hA101, 1'b0, 3'h0, 6'h01, 3'h1, 1'b0}, '{16'hA102, 1'b0, 3'h0, 6'h3D, 3'h0, 1'b0},
      '{16'hA104, 1'b0, 3'h0, 6'h04, 3'h1, 1'b0}, '{16'hA108, 1'b0, 3'h0, 6'h08, 3'h1, 1'b0},
      '{16'hA110, 1'b0, 3'h0, 6'h10, 3'h1, 1'b0}, '{16'hA120, 1'b0, 3'h0, 6'h20, 3'h1, 1'b0},
      '{16'hA104, 1'b1, 3'h0, 6'h3F, 3'h0, 1'b1}, '{16'hA103, 1'b0, 3'h0, 6'h3F, 3'h0, 1'b1},
      '{16'hAA01, 1'b0, 3'h3, 6'h00, 3'h3, 1'b0}, '{16'hAA08, 1'b0, 3'h3, 6'h00, 3'h1, 1'b0},
      '{16'hAB01, 1'b0, 3'h1, 6'h00, 3'h2, 1'b0}, '{16'hAB02, 1'b0, 3'h1, 6'h00, 3'h3, 1'b0},
      '{16'hB000, 1'b0, 3'h1, 6'h00, 3'h4, 1'b0}, '{16'hB100, 1'b0, 3'h1, 6'h00, 3'h5, 1'b0},
      '{16'hB301, 1'b0, 3'h1, 6'h00, 3'h6, 1'b0}, '{16'hB302, 1'b0, 3'h1, 6'h00, 3'h7, 1'b0},
      '{16'hB304, 1'b0, 3'h2, 6'h00, 3'h1, 1'b0}, '{16'hAA02, 1'b0, 3'h1, 6'h00, 3'h0, 1'b1},
      '{16'h0000, 1'b0, 3'h1, 6'h3F, 3'h0, 1'b0}, '{16'hAA01, 1'b1, 3'h5, 6'h00, 3'h5, 1'b0}};
   pesd_src_model i_src (.amt(amt), .ports(ports), .src(src));
   pesd_decode #(.NUM_CNT(2)) i_dut (.ref_clk(ref_clk), .rst(rst), .sel_in(sel_in),
      .sel_load(sel_load), .cnt_enable(cnt_enable), .src(src), .cnt_inc_q(cnt_inc_q),
      .cnt_hit_q(cnt_hit_q), .sel_bad_q(sel_bad_q), .sel_q(sel_q));
   // compare one value, count it
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // load a selection, then present occurrences for one cycle
   task automatic run_row(input pesd_row_s r);
      @(negedge ref_clk);
      sel_in[r.cnt] = r.sel;
      sel_load[r.cnt] = 1'b1;
      @(negedge ref_clk);
      sel_load = 2'h0;
      amt = r.amt;
      ports = r.ports;
      @(negedge ref_clk);
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   // hang guard
   initial begin
      repeat (2000) @(posedge ref_clk);
      n_fail++;
      final_report();
   end
   initial begin
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      chk(16'({cnt_inc_q, cnt_hit_q, sel_bad_q}), 16'h0000);
      chk(sel_q[0] | sel_q[1], 16'h0000);
      $display("reset test done");
      foreach (rows[i]) begin
         run_row(rows[i]);
         chk(16'(cnt_inc_q[rows[i].cnt]), 16'(rows[i].inc));
         chk(16'(sel_bad_q[rows[i].cnt]), 16'(rows[i].bad));
         chk(16'(cnt_hit_q[rows[i].cnt]), 16'(rows[i].inc != 3'h0));
         chk(sel_q[rows[i].cnt], rows[i].sel);
         $display("row %0d done", i);
      end
      cnt_enable = 2'h2;
      run_row(pesd_row_s'{16'hAB02, 1'b0, 3'h1, 6'h00, 3'h0, 1'b0});
      chk(16'({cnt_inc_q[0], cnt_hit_q[0]}), 16'h0000);
      cnt_enable = 2'h3;
      $display("enable test done");
      run_row(pesd_row_s'{16'hAA01, 1'b0, 3'h3, 6'h00, 3'h3, 1'b0});
      for (int k = 0; k < 4; k++) begin
         amt = 3'(k + 4);
         @(negedge ref_clk);
         chk(16'(cnt_inc_q[0]), 16'(k + 4));
      end
      sel_in[0] = 16'hA101;
      sel_load = 2'h1;
      @(negedge ref_clk);
      sel_in[0] = 16'hA102;
      @(negedge ref_clk);
      sel_load = 2'h0;
      ports = 6'h02;
      @(negedge ref_clk);
      chk(16'(cnt_inc_q[0]), 16'h0001);
      $display("back to back test done");
      rst = 1'b1;
      @(negedge ref_clk);
      chk(16'({cnt_inc_q, cnt_hit_q, sel_bad_q}), 16'h0000);
      chk(sel_q[0] | sel_q[1], 16'h0000);
      rst = 1'b0;
      // decoder must count again right after the mid-run reset
      run_row(rows[8]);
      chk(16'(cnt_inc_q[0]), 16'(rows[8].inc));
      chk(sel_q[0], rows[8].sel);
      chk(16'(sel_bad_q[0]), 16'h0000);
      $display("mid reset test done");
      final_report();
   end
endmodule
bind pesd_decode pesd_decode_props #(.NUM_CNT(NUM_CNT)) i_props (.ref_clk(ref_clk),
   .rst(rst), .sel_in(sel_in), .sel_load(sel_load), .cnt_enable(cnt_enable), .src(src),
   .cnt_inc_q(cnt_inc_q), .cnt_hit_q(cnt_hit_q), .sel_bad_q(sel_bad_q), .sel_q(sel_q));
`default_nettype wire
